/* pkg/spp_defines.svh */
`ifndef SPP_DEFINES_SVH
`define SPP_DEFINES_SVH
// Register index (printed offsets are not all multiples of four)
`define SPP_IDX_PA_DATA   12'h000
`define SPP_IDX_RSVD1     12'h001
`define SPP_IDX_PA_DIR    12'h002
`define SPP_IDX_RSVD3     12'h003
`define SPP_IDX_PC_DIR    12'h006
`define SPP_IDX_PD_DIR    12'h007
`define SPP_IDX_PA_PIN    12'h120
`define SPP_IDX_RSVD121   12'h121
`define SPP_IDX_PA_DRV    12'h122
// Field widths and reset values
`define SPP_PA_W          6
`define SPP_PC_W          2
`define SPP_PD_W          8
`define SPP_RST_PA        6'h00
`define SPP_RST_PC        2'h0
`define SPP_RST_PD        8'h00
`define SPP_RST_OEN       6'h3F
// SPI pin positions
`define SPP_PIN_MISO      0
`define SPP_PIN_MOSI      1
`define SPP_PIN_SCK       2
`define SPP_PIN_SS        3
`endif

/* pkg/spp_pkg.sv */
`default_nettype none
package spp_pkg;
  // Per-pin SPI claim with its drive level and direction
  typedef struct packed {
    logic [5:0] claim;
    logic [5:0] dout;
    logic [5:0] oe;
  } spp_spi_t;
  // Per-pin drive to the pad ring
  typedef struct packed {
    logic [5:0] dout;
    logic [5:0] oe_n;
    logic [5:0] reduce;
  } spp_pad_t;
endpackage
`default_nettype wire

/* logic/spp_port.sv */
// Functional notes
// - Data read gives latch if output, else pin
// - Pin 3 slave select, pin 2 serial clock
// - Pin 1 MOSI, pin 0 MISO
// - Unclaimed pins are plain general purpose I/O
// - Direction register has bits 5 to 0
// - Active SPI decides direction of its pins
// - SPI override leaves direction bits unchanged
// - Direction 1 drives, 0 is high-impedance input
// - Writes to reserved locations are ignored
// - Reserved 0x0003 always reads zero
// - Data register reset zero, bits 7:6 zero
// - Input register shows synchronized pin states
// - Per-pin reduced drive register bits
//
// Chosen here: the APB interface to the registers.
`include "spp_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module spp_port
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [13:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire spp_pkg::spp_spi_t spi_in,
  output logic      [5:0]       spi_pin_level,
  input  wire logic [5:0]       pad_in,
  output spp_pkg::spp_pad_t     pad_out,
  output logic      [1:0]       portc_dir_bits,
  output logic      [7:0]       portd_dir_bits
);

  // ==========================================
  // Bus decode
  // ==========================================
  logic [11:0] idx;
  logic        wr_acc;
  logic        rd_acc;
  logic        word_ok;
  assign word_ok = (paddr[1:0] == 2'h0);
  assign idx     = paddr[13:2];
  // Writes land only at the edge where the master sees pready high,
  // so a master that stretches its access phase never writes early.
  // Reads are decoded in the first access cycle; the answer is a flop
  // that stands exactly in the cycle in which pready is high.
  assign wr_acc  = psel & penable & pwrite & pready & word_ok;
  assign rd_acc  = psel & penable & ~pwrite;

  // Index match, shared by write and read decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  // ==========================================
  // Pin synchronisers
  // ==========================================
  logic [5:0] pin_meta_reg;
  logic [5:0] pin_sync_reg;
  // Two stages before any logic looks at the pads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_reg <= `SPP_RST_PA;
      pin_sync_reg <= `SPP_RST_PA;
    end
    else
    begin
      pin_meta_reg <= pad_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ==========================================
  // Port registers
  // ==========================================
  logic [5:0] porta_data_bits;
  logic [5:0] porta_dir_bits;
  logic [5:0] porta_drive_reduce_bits;
  logic [1:0] portc_dir_reg;
  logic [7:0] portd_dir_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      porta_data_bits <= `SPP_RST_PA;
    else if (wr_acc && hit(idx, `SPP_IDX_PA_DATA))
      porta_data_bits <= pwdata[5:0];
  end

  // six direction bits, never touched by SPI
  // only a bus write changes them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      porta_dir_bits <= `SPP_RST_PA;
    else if (wr_acc && hit(idx, `SPP_IDX_PA_DIR))
      porta_dir_bits <= pwdata[5:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      porta_drive_reduce_bits <= `SPP_RST_PA;
    else if (wr_acc && hit(idx, `SPP_IDX_PA_DRV))
      porta_drive_reduce_bits <= pwdata[5:0];
  end

  // Port C and D direction layouts only; their pins live elsewhere
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      portc_dir_reg <= `SPP_RST_PC;
      portd_dir_reg <= `SPP_RST_PD;
    end
    else
    begin
      if (wr_acc && hit(idx, `SPP_IDX_PC_DIR))
        portc_dir_reg <= pwdata[1:0];
      if (wr_acc && hit(idx, `SPP_IDX_PD_DIR))
        portd_dir_reg <= pwdata[7:0];
    end
  end
  // reserved indices have no write branch above, so writes drop

  // ==========================================
  // Pad muxing
  // ==========================================
  spp_pkg::spp_pad_t pad_next;
  logic [5:0]        dir_eff;
  // pins 3 and 2 carry slave select and serial clock when claimed
  // pins 1 and 0 carry MOSI and MISO when claimed
  // unclaimed pins follow the port registers
  // a claimed pin takes its direction from the SPI
  always_comb
  begin
    dir_eff           = (spi_in.claim & spi_in.oe) | (~spi_in.claim & porta_dir_bits);
    pad_next.dout     = (spi_in.claim & spi_in.dout) | (~spi_in.claim & porta_data_bits);
    // direction 1 drives the pad, 0 leaves it released
    pad_next.oe_n     = ~dir_eff;
    pad_next.reduce   = porta_drive_reduce_bits;
  end

  // Registered pad drive keeps outputs glitch free
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // All pads released while in reset
      pad_out       <= '{dout: `SPP_RST_PA, oe_n: `SPP_RST_OEN, reduce: `SPP_RST_PA};
      spi_pin_level <= `SPP_RST_PA;
    end
    else
    begin
      pad_out       <= pad_next;
      spi_pin_level <= pin_sync_reg;   // SPI sees the synchronized levels
    end
  end

  // Direction copies for ports C and D leave as flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      portc_dir_bits <= `SPP_RST_PC;
      portd_dir_bits <= `SPP_RST_PD;
    end
    else
    begin
      portc_dir_bits <= portc_dir_reg;
      portd_dir_bits <= portd_dir_reg;
    end
  end

  // ==========================================
  // Read path
  // ==========================================
  logic [31:0] rd_next;
  logic [5:0]  porta_pin_input_bits;
  assign porta_pin_input_bits = pin_sync_reg;
  always_comb
  begin
    rd_next = 32'h0000_0000;
    // output pins read the latch, inputs the synced pin
    if (hit(idx, `SPP_IDX_PA_DATA))
      rd_next[5:0] = (porta_dir_bits & porta_data_bits) |
                     (~porta_dir_bits & porta_pin_input_bits);
    else if (hit(idx, `SPP_IDX_PA_DIR))
      rd_next[5:0] = porta_dir_bits;
    else if (hit(idx, `SPP_IDX_PC_DIR))
      rd_next[1:0] = portc_dir_reg;
    else if (hit(idx, `SPP_IDX_PD_DIR))
      rd_next[7:0] = portd_dir_reg;
    // input register always shows the pins
    else if (hit(idx, `SPP_IDX_PA_PIN))
      rd_next[5:0] = porta_pin_input_bits;
    else if (hit(idx, `SPP_IDX_PA_DRV))
      rd_next[5:0] = porta_drive_reduce_bits;
    // slot three and other reserved slots fall through as zero
    // upper bits and reserved ranges stay zero
  end

  // One wait state: answer registered in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      prdata  <= (rd_acc && !pready) ? rd_next : 32'h0000_0000;
      pslverr <= 1'b0;   // Unmapped space reads zero, no error
    end
  end

  // ==========================================
  // Assertions
  // ==========================================
  // Output pin reads the latch
  pa_read_mux_a : assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && !pready && hit(idx, `SPP_IDX_PA_DATA))
    |=> (prdata[5:0] == (($past(porta_dir_bits) & $past(porta_data_bits)) |
         (~$past(porta_dir_bits) & $past(pin_sync_reg)))))
    else $error("data read mux wrong");
  // Claimed pin direction from SPI
  spi_dir_ovr_a : assert property (@(posedge pclk) disable iff (!presetn)
    spi_in.claim[`SPP_PIN_SCK]
    |=> (pad_out.oe_n[`SPP_PIN_SCK] == ~$past(spi_in.oe[`SPP_PIN_SCK])))
    else $error("sck direction not from spi");
  // Direction bits hold without a write
  dir_hold_a : assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_acc && hit(idx, `SPP_IDX_PA_DIR))
    |=> $stable(porta_dir_bits))
    else $error("direction bits changed");
  // General purpose output enable follows direction
  gpio_oe_a : assert property (@(posedge pclk) disable iff (!presetn)
    !spi_in.claim[4]
    |=> (pad_out.oe_n[4] == ~$past(porta_dir_bits[4])))
    else $error("gpio direction wrong");
  // Reserved slot reads zero
  rsvd_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && hit(idx, `SPP_IDX_RSVD3))
    |=> (prdata == 32'h0000_0000))
    else $error("reserved read nonzero");
  // Drive reduce reaches pads
  drv_reduce_a : assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> (pad_out.reduce == $past(porta_drive_reduce_bits)))
    else $error("reduce not applied");
  // Master out level reaches pin 1
  mosi_level_a : assert property (@(posedge pclk) disable iff (!presetn)
    spi_in.claim[`SPP_PIN_MOSI]
    |=> (pad_out.dout[`SPP_PIN_MOSI] == $past(spi_in.dout[`SPP_PIN_MOSI])))
    else $error("mosi level wrong");
  // Master in level reaches pin 0
  miso_level_a : assert property (@(posedge pclk) disable iff (!presetn)
    spi_in.claim[`SPP_PIN_MISO]
    |=> (pad_out.dout[`SPP_PIN_MISO] == $past(spi_in.dout[`SPP_PIN_MISO])))
    else $error("miso level wrong");
  // Write lands in data latch
  data_write_a : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(idx, `SPP_IDX_PA_DATA))
    |=> (porta_data_bits == $past(pwdata[5:0])))
    else $error("data write lost");
  // Slave select level reaches pin 3
  ss_level_a : assert property (@(posedge pclk) disable iff (!presetn)
    spi_in.claim[`SPP_PIN_SS]
    |=> (pad_out.dout[`SPP_PIN_SS] == $past(spi_in.dout[`SPP_PIN_SS])))
    else $error("slave select level wrong");
  // Serial clock level reaches pin 2
  sck_level_a : assert property (@(posedge pclk) disable iff (!presetn)
    spi_in.claim[`SPP_PIN_SCK]
    |=> (pad_out.dout[`SPP_PIN_SCK] == $past(spi_in.dout[`SPP_PIN_SCK])))
    else $error("sck level wrong");
  // Unclaimed pin drives the latch
  gpio_dout_a : assert property (@(posedge pclk) disable iff (!presetn)
    !spi_in.claim[5]
    |=> (pad_out.dout[5] == $past(porta_data_bits[5])))
    else $error("gpio level wrong");
  // Direction read has six bits only
  dir_width_a : assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && !pready && hit(idx, `SPP_IDX_PA_DIR))
    |=> (prdata == {26'h0, $past(porta_dir_bits)}))
    else $error("direction read wrong");
  // Reserved write changes nothing
  rsvd_write_a : assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && pready && hit(idx, `SPP_IDX_RSVD1))
    |=> ($stable(porta_data_bits) && $stable(porta_dir_bits)))
    else $error("reserved write took effect");
  // Data read has zero upper bits
  data_upper_a : assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && !pready && hit(idx, `SPP_IDX_PA_DATA))
    |=> (prdata[31:6] == 26'h0))
    else $error("data upper bits nonzero");
  // Input register shows synced pins
  pin_read_a : assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && !pready && hit(idx, `SPP_IDX_PA_PIN))
    |=> (prdata == {26'h0, $past(pin_sync_reg)}))
    else $error("pin input read wrong");
  // Second sync stage reads only the first
  pin_sync_a : assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> (pin_sync_reg == $past(pin_meta_reg)))
    else $error("pin sync chain broken");
  // Bus never reports an error
  no_slverr_a : assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> !pslverr)
    else $error("slave error raised");
  // Answer stands for one cycle only
  ready_pulse_a : assert property (@(posedge pclk) disable iff (!presetn)
    pready
    |=> !pready)
    else $error("pready held too long");

endmodule
`default_nettype wire

/* tb/spp_pad_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ====================
// Pad ring seen from outside
module spp_pad_model
(
  input  wire spp_pkg::spp_pad_t pad_out,
  input  wire logic [5:0]        ext,
  output logic      [5:0]        pad_in
);
  assign pad_in = (~pad_out.oe_n & pad_out.dout) | (pad_out.oe_n & ext);
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic              pready;
  logic              pslverr;
  logic [13:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic [31:0]       rd;
  logic              err;
  logic [31:0]       seed;
  logic [31:0]       ex[10];
  logic [13:0]       ad[10];
  logic [13:0]       rs[5];
  spp_pkg::spp_spi_t spi_in;
  spp_pkg::spp_pad_t pad_out;
  logic [5:0]        spi_pin_level;
  logic [5:0]        pad_in;
  logic [5:0]        ext;
  logic [5:0]        dat;
  logic [5:0]        dir;
  logic [5:0]        drv;
  logic [5:0]        lv;
  logic [5:0]        en_n;
  logic [1:0]        pc;
  logic [7:0]        pd;
  logic [1:0]        portc_dir_bits;
  logic [7:0]        portd_dir_bits;
  int                num_errors;
  int                check_count;
  int                cyc;

  spp_port uut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spi_in(spi_in),
    .spi_pin_level(spi_pin_level), .pad_in(pad_in), .pad_out(pad_out),
    .portc_dir_bits(portc_dir_bits), .portd_dir_bits(portd_dir_bits)
  );
  spp_pad_model pads (.pad_out(pad_out), .ext(ext), .pad_in(pad_in));

  // ====================
  // Clock and hang guard
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      conclude();
    end
  end

  // ====================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; an idle cycle after avoids double drives
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Reference levels, drives and readback of every location
  task automatic verify();
    lv = (spi_in.claim & ((spi_in.oe & spi_in.dout) | (~spi_in.oe & ext)))
       | (~spi_in.claim & ((dir & dat) | (~dir & ext)));
    en_n = ~((spi_in.claim & spi_in.oe) | (~spi_in.claim & dir));
    check(32'(pad_out.oe_n), 32'(en_n));
    check(32'(pad_out.dout & ~en_n), 32'(lv & ~en_n));
    check(32'(pad_out.reduce), 32'(drv));
    check(32'(spi_pin_level), 32'(lv));
    check(32'({portd_dir_bits, portc_dir_bits}), 32'({pd, pc}));
    ex = '{(dir & dat) | (~dir & lv), 0, dir, 0, pc, pd, lv, 0, drv, 0};
    foreach (ad[i])
    begin
      apb(1'b0, ad[i], 32'h0);
      check(rd, ex[i]);
      check(32'(err), 32'h0);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ====================
  // Main sequence
  initial
  begin
    ad = '{14'h000, 14'h004, 14'h008, 14'h00C, 14'h018, 14'h01C, 14'h480, 14'h484,
           14'h488, 14'h020};
    rs = '{14'h004, 14'h00C, 14'h484, 14'h020, 14'h001};
    seed = 32'd52812;
    {presetn, psel, penable, pwrite, paddr, pwdata, spi_in, ext} = '0;
    {dat, dir, drv, pc, pd} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    verify();
    repeat (40)
    begin
      apb(1'b1, 14'h000, rnd());
      dat = pwdata[5:0];
      apb(1'b1, 14'h008, rnd());
      dir = pwdata[5:0];
      apb(1'b1, 14'h488, rnd());
      drv = pwdata[5:0];
      apb(1'b1, 14'h018, rnd());
      pc = pwdata[1:0];
      apb(1'b1, 14'h01C, rnd());
      pd = pwdata[7:0];
      foreach (rs[i]) apb(1'b1, rs[i], rnd());
      ext <= 6'(rnd());
      spi_in <= 18'(rnd());
      repeat (5) @(posedge pclk);
      verify();
    end
    conclude();
  end
endmodule
`default_nettype wire
